// ==== hdl/tc_decode.sv ====
`timescale 1ns/10ps
module tc_decode (
  // Control word in, tree geometry out
  tree_cfg_if.decoder cfg
);
  import tree_walk_pkg::*;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [3:0] raw [4];
  genvar g;
  for (g = 0; g < 4; g++) begin : g_field
    assign raw[g] = cfg.tc[TC_LVL_A_LSB - TC_FIELD_W * g +: TC_FIELD_W];
  end

  wire [3:0] shiftW = cfg.tc[TC_SHIFT_LSB +: TC_FIELD_W];
  wire [3:0] pageW  = cfg.tc[TC_PAGE_LSB +: TC_FIELD_W];
  // First zero field ends the tree; later ones are disregarded
  wire [3:0] effB   = raw[1];
  wire [3:0] effC   = (raw[1] != 4'h0) ? raw[2] : 4'h0;
  wire [3:0] effD   = (raw[1] != 4'h0 && raw[2] != 4'h0) ? raw[3] : 4'h0;
  wire [3:0] fcW    = cfg.tc[TC_FC_LOOKUP] ? FC_INDEX_W : 4'h0;

  // ----------------------------------------------------------------
  // Level widths and low bit of each index
  // ----------------------------------------------------------------
  assign cfg.levelWidth  = {effD, effC, effB, raw[0], fcW};
  // Level A starts at bit 31-shift; FC slot holds 32-shift, one above A's top bit
  assign cfg.levelLow[1] = ADDR_BITS - 6'(shiftW) - 6'(raw[0]);
  assign cfg.levelLow[0] = ADDR_BITS - 6'(shiftW);
  for (g = 2; g < 5; g++) begin : g_low
    assign cfg.levelLow[g] = cfg.levelLow[g-1] - 6'(cfg.levelWidth[g]);
  end

  assign cfg.pageBits  = pageW;
  assign cfg.lastLevel = (effD != 4'h0) ? LVL_D :
                         (effC != 4'h0) ? LVL_C :
                         (effB != 4'h0) ? LVL_B : LVL_A;

  // ----------------------------------------------------------------
  // Geometry check: every address bit accounted for exactly once
  // ----------------------------------------------------------------
  wire [6:0] bitSum = 7'(shiftW) + 7'(pageW) + 7'(raw[0]) + 7'(effB) + 7'(effC) + 7'(effD);
  assign cfg.cfgError = (bitSum != 7'(ADDR_BITS)) || (raw[0] == 4'h0) ||
                        (effB == 4'h0 && raw[0] < 4'h2) || (pageW < PAGE_MIN);
endmodule

// ==== hdl/translation_tree_walk_control.sv ====
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
// Operation
// [RULE1] Control register sets page size, supervisor root choice, FC lookup, level widths.
// [RULE2] Initial shift drops up to 15 top address bits from lookup.
// [RULE3] Page-size low bits form the byte offset, never a table index.
// [RULE4] Page size is a power of two from 256 bytes to 32K bytes.
// [RULE5] With FC lookup, top level is indexed by the three function code bits.
// [RULE6] Next level is indexed by top address bits below the shift, level A width.
// [RULE7] First zero width among B..D ends tree; last nonzero level holds pages.
// [RULE8] Software makes shift, page size and used widths total 32 bits.
// [RULE9] Level A starts at 31-shift, 1-15 bits, two if B unused.
// [RULE10] C ignored when B zero; D ignored when B or C zero.
// [RULE11] Up to five levels; FC level and levels B, C, D optional.
// [RULE12] Root limit bounds the first-level index.
// [RULE13] Walker knows table, page, invalid, indirect kinds, short and long.
// [RULE14] Root pointer is only a table or early-termination page descriptor.
// [RULE15] Early-termination page stops search; base maps a contiguous block.
// [RULE16] Middle tables hold table, early-termination page or invalid entries.
// [RULE17] Bottom tables hold page, indirect or invalid; indirect costs one more fetch.
// [RULE18] Short descriptors one word, no limits; long two words; root always long.
// [RULE19] Software keeps one format within each table.
// [RULE20] Descriptor type is always the two low bits of the first word.
// [RULE21] Invalid descriptor below the root ends search with a bus error.
// [RULE22] Unused descriptor fields are ignored by the walker.
// [RULE23] Function code 7 bypasses translation; address passes unchanged.
// [RULE24] Reset clears translation enable so addresses pass unchanged.
// [RULE25] Descriptor type encodings come from one shared enumeration.
// [RULE26] Bad geometry flags a configuration error instead of searching.
module translation_tree_walk_control (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  // Register port
  input  wire logic [tree_walk_pkg::REG_AW-1:0] regAddr,
  input  wire logic [31:0]                 regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [31:0]                 regRdata,
  // Translation request and answer
  input  wire logic                        transReq,
  input  wire logic [2:0]                  transFc,
  input  wire logic [31:0]                 transAddr,
  output logic                             transDone,
  output logic      [31:0]                 transPhys,
  output logic                             transBusErr,
  output logic                             transCfgErr,
  // Descriptor fetch port
  output logic                             fetchReq,
  output logic      [31:0]                 fetchAddr,
  input  wire logic                        fetchAck,
  input  wire logic [31:0]                 fetchData
);
  import tree_walk_pkg::*;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [31:0] control;
  logic [31:0] cpuRootHi;
  logic [31:0] cpuRootLo;
  logic [31:0] supRootHi;
  logic [31:0] supRootLo;
  logic        stickyBus;
  logic        stickyCfg;

  // ----------------------------------------------------------------
  // Walker state
  // ----------------------------------------------------------------
  walk_state_t      state;
  level_t           level;
  logic [31:0]      tblBase;
  logic             entLong;
  logic [14:0]      limVal;
  logic             limLower;
  logic             limOn;
  logic [31:0]      word0;
  logic [31:0]      descAddr;
  logic             indir;
  logic [2:0]       curFc;
  logic [31:0]      curAddr;

  walk_state_t      next_state;
  level_t           next_level;
  logic [31:0]      next_tblBase;
  logic             next_entLong;
  logic [14:0]      next_limVal;
  logic             next_limLower;
  logic             next_limOn;
  logic [31:0]      next_word0;
  logic [31:0]      next_descAddr;
  logic             next_indir;
  logic [2:0]       next_curFc;
  logic [31:0]      next_curAddr;
  logic             next_fetchReq;
  logic [31:0]      next_fetchAddr;
  logic             next_transDone;
  logic [31:0]      next_transPhys;
  logic             next_transBusErr;
  logic             next_transCfgErr;

  // ----------------------------------------------------------------
  // Geometry decoder
  // ----------------------------------------------------------------
  tree_cfg_if cfg ();
  assign cfg.tc = control;

  tc_decode u_decode (
    .cfg (cfg.decoder)
  );

  // Replace the offset part of a base with the logical address bits
  function automatic logic [31:0] joinAddr(input logic [31:0] base,
                                           input logic [31:0] addr,
                                           input logic [5:0]  bits);
    joinAddr = (base & ~lowMask(bits)) | (addr & lowMask(bits));
  endfunction

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wrControl = regWr && regAddr == OFF_CONTROL;
  wire wrCpuHi   = regWr && regAddr == OFF_CPU_HI;
  wire wrCpuLo   = regWr && regAddr == OFF_CPU_LO;
  wire wrSupHi   = regWr && regAddr == OFF_SUP_HI;
  wire wrSupLo   = regWr && regAddr == OFF_SUP_LO;
  wire wrStatus  = regWr && regAddr == OFF_STATUS;

  wire [31:0] statusWord = {28'h0, state != S_IDLE, cfg.cfgError, stickyCfg, stickyBus};

  // Unmapped offsets read as zero
  wire [31:0] readMux = (regAddr == OFF_CONTROL) ? control   :
                        (regAddr == OFF_CPU_HI)  ? cpuRootHi :
                        (regAddr == OFF_CPU_LO)  ? cpuRootLo :
                        (regAddr == OFF_SUP_HI)  ? supRootHi :
                        (regAddr == OFF_SUP_LO)  ? supRootLo :
                        (regAddr == OFF_STATUS)  ? statusWord :
                        (regAddr == OFF_RESULT)  ? transPhys : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Walk datapath
  // ----------------------------------------------------------------
  // Supervisor accesses use their own root only when enabled
  wire        useSup    = curFc[2] && control[TC_SUP_ROOT]; // see [RULE1]
  wire [31:0] rootHi    = useSup ? supRootHi : cpuRootHi;
  wire [31:0] rootLo    = useSup ? supRootLo : cpuRootLo;
  wire        bypass    = transFc == FC_CPU_SPACE || !control[TC_ENABLE]; // see [RULE23]
  wire [5:0]  lvlLow    = cfg.levelLow[level];
  wire [3:0]  lvlW      = cfg.levelWidth[level];
  wire [5:0]  pageBits  = 6'(cfg.pageBits); // see [RULE3] [RULE4]

  // Function code indexes the top level, address bits the rest
  wire [31:0] index     = (level == LVL_FC) ? {29'h0, curFc} :          // see [RULE5]
                          (curAddr >> lvlLow) & lowMask(6'(lvlW));      // see [RULE6] [RULE9]
  wire [31:0] limWide   = {17'h0, limVal};
  wire        limitBad  = limOn && (limLower ? index < limWide : index > limWide); // see [RULE12]
  // Entry size follows the pointing descriptor's type
  wire [31:0] entryAddr = tblBase + (entLong ? index << 3 : index << 2); // see [RULE19]
  desc_type_t rootType;
  desc_type_t descType;
  assign rootType = desc_type_t'(rootHi[1:0]);
  assign descType = desc_type_t'(word0[1:0]); // see [RULE20] [RULE25]
  wire        atLast    = level == cfg.lastLevel; // see [RULE7] [RULE10]

  // ----------------------------------------------------------------
  // Walk sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_level       = level;
    next_tblBase     = tblBase;
    next_entLong     = entLong;
    next_limVal      = limVal;
    next_limLower    = limLower;
    next_limOn       = limOn;
    next_word0       = word0;
    next_descAddr    = descAddr;
    next_indir       = indir;
    next_curFc       = curFc;
    next_curAddr     = curAddr;
    next_fetchReq    = fetchReq;
    next_fetchAddr   = fetchAddr;
    next_transDone   = 1'b0;
    next_transPhys   = transPhys;
    next_transBusErr = 1'b0;
    next_transCfgErr = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (transReq) begin
          next_curFc   = transFc;
          next_curAddr = transAddr;
          next_indir   = 1'b0;
          if (bypass) begin
            // Untranslated: logical address is the physical one
            next_transDone = 1'b1; // see [RULE23] [RULE24]
            next_transPhys = transAddr;
          end else if (cfg.cfgError) begin
            // Never walk a tree whose geometry does not add up
            next_transDone   = 1'b1; // see [RULE26] [RULE8]
            next_transCfgErr = 1'b1;
          end else begin
            next_state = S_ROOT;
          end
        end
      end
      S_ROOT: begin
        // Root is always long form: limit in upper word, base in lower
        unique case (rootType) // see [RULE14] [RULE18]
          DT_PAGE: begin
            next_state     = S_IDLE;
            next_transDone = 1'b1; // see [RULE15]
            next_transPhys = joinAddr(rootLo, curAddr, cfg.levelLow[0]);
          end
          DT_SHORT, DT_LONG: begin
            next_state    = S_INDEX;
            next_tblBase  = rootLo & ALIGN_MASK;
            next_entLong  = rootType == DT_LONG;
            next_limVal   = rootHi[RP_LIMIT_LSB +: RP_LIMIT_W]; // see [RULE12]
            next_limLower = rootHi[RP_LOWER_LIM];
            next_limOn    = 1'b1;
            next_level    = control[TC_FC_LOOKUP] ? LVL_FC : LVL_A; // see [RULE11]
          end
          DT_INVALID: begin
            // Root may not be invalid
            next_state       = S_IDLE;
            next_transDone   = 1'b1;
            next_transBusErr = 1'b1;
          end
        endcase
      end
      S_INDEX: begin
        if (limitBad) begin
          next_state       = S_IDLE;
          next_transDone   = 1'b1;
          next_transBusErr = 1'b1;
        end else begin
          next_state     = S_FETCH0;
          next_fetchReq  = 1'b1;
          next_fetchAddr = entryAddr;
        end
      end
      S_FETCH0: begin
        if (fetchAck) begin
          next_word0    = fetchData;
          next_descAddr = fetchData & ALIGN_MASK;
          if (entLong) begin
            // Long form: second word carries the address
            next_state     = S_FETCH1; // see [RULE18]
            next_fetchAddr = fetchAddr + 32'h4;
          end else begin
            next_state    = S_DECODE;
            next_fetchReq = 1'b0;
          end
        end
      end
      S_FETCH1: begin
        if (fetchAck) begin
          next_state    = S_DECODE;
          next_fetchReq = 1'b0;
          next_descAddr = fetchData & ALIGN_MASK;
        end
      end
      S_DECODE: begin
        // Only the type, limit and address fields are looked at
        next_state = S_IDLE; // see [RULE22] [RULE13]
        if (descType == DT_INVALID) begin
          next_transDone   = 1'b1; // see [RULE21]
          next_transBusErr = 1'b1;
        end else if (descType == DT_PAGE) begin
          next_transDone = 1'b1;
          // Bottom or indirect target: page; higher up: early termination
          next_transPhys = (atLast || indir) ? joinAddr(descAddr, curAddr, pageBits) :
                           joinAddr(descAddr, curAddr, lvlLow); // see [RULE15] [RULE16]
        end else if (indir) begin
          // An indirect target must itself be a page
          next_transDone   = 1'b1;
          next_transBusErr = 1'b1;
        end else if (atLast) begin
          // Indirect: one extra fetch of the shared page descriptor
          next_state     = S_FETCH0; // see [RULE17]
          next_indir     = 1'b1;
          next_entLong   = descType == DT_LONG;
          next_fetchReq  = 1'b1;
          next_fetchAddr = descAddr;
        end else begin
          // Pointer to the next level; only long form has a limit
          next_state    = S_INDEX; // see [RULE16] [RULE18]
          next_tblBase  = descAddr;
          next_entLong  = descType == DT_LONG;
          next_limOn    = entLong;
          next_limVal   = word0[RP_LIMIT_LSB +: RP_LIMIT_W];
          next_limLower = word0[RP_LOWER_LIM];
          next_level    = level_t'(level + 3'h1);
        end
      end
      default: begin
        next_state    = S_IDLE;
        next_fetchReq = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Walker flops
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state       <= S_IDLE;
      level       <= LVL_A;
      tblBase     <= 32'h0000_0000;
      entLong     <= 1'b0;
      limVal      <= 15'h0000;
      limLower    <= 1'b0;
      limOn       <= 1'b0;
      word0       <= 32'h0000_0000;
      descAddr    <= 32'h0000_0000;
      indir       <= 1'b0;
      curFc       <= 3'h0;
      curAddr     <= 32'h0000_0000;
      fetchReq    <= 1'b0;
      fetchAddr   <= 32'h0000_0000;
      transDone   <= 1'b0;
      transPhys   <= 32'h0000_0000;
      transBusErr <= 1'b0;
      transCfgErr <= 1'b0;
    end else begin
      state       <= next_state;
      level       <= next_level;
      tblBase     <= next_tblBase;
      entLong     <= next_entLong;
      limVal      <= next_limVal;
      limLower    <= next_limLower;
      limOn       <= next_limOn;
      word0       <= next_word0;
      descAddr    <= next_descAddr;
      indir       <= next_indir;
      curFc       <= next_curFc;
      curAddr     <= next_curAddr;
      fetchReq    <= next_fetchReq;
      fetchAddr   <= next_fetchAddr;
      transDone   <= next_transDone;
      transPhys   <= next_transPhys;
      transBusErr <= next_transBusErr;
      transCfgErr <= next_transCfgErr;
    end
  end

  // ----------------------------------------------------------------
  // Control and root registers; reset disables translation
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      control   <= CONTROL_RESET; // see [RULE24]
      cpuRootHi <= ROOT_RESET;
      cpuRootLo <= ROOT_RESET;
      supRootHi <= ROOT_RESET;
      supRootLo <= ROOT_RESET;
    end else begin
      if (wrControl) control   <= regWdata; // see [RULE1] [RULE2]
      if (wrCpuHi)   cpuRootHi <= regWdata;
      if (wrCpuLo)   cpuRootLo <= regWdata;
      if (wrSupHi)   supRootHi <= regWdata;
      if (wrSupLo)   supRootLo <= regWdata;
    end
  end

  // ----------------------------------------------------------------
  // Sticky error flags; a new error wins over a clear in one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stickyBus <= 1'b0;
      stickyCfg <= 1'b0;
    end else begin
      stickyBus <= next_transBusErr || (stickyBus && !(wrStatus && regWdata[ST_BUS_ERR]));
      stickyCfg <= next_transCfgErr || (stickyCfg && !(wrStatus && regWdata[ST_CFG_ERR]));
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= regRd ? readMux : 32'h0000_0000;
    end
  end

endmodule

// ==== hdl/tree_cfg_if.sv ====
`timescale 1ns/10ps
interface tree_cfg_if;
  import tree_walk_pkg::*;

  logic [31:0]      tc;
  logic [4:0][3:0]  levelWidth;
  logic [4:0][5:0]  levelLow;
  level_t           lastLevel;
  logic [3:0]       pageBits;
  logic             cfgError;

  modport decoder (input tc, output levelWidth, levelLow, lastLevel, pageBits, cfgError);
  modport walker  (output tc, input levelWidth, levelLow, lastLevel, pageBits, cfgError);
endinterface

// ==== hdl/tree_walk_pkg.sv ====
package tree_walk_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam int         REG_AW         = 5;
  localparam logic [4:0] OFF_CONTROL    = 5'h00;
  localparam logic [4:0] OFF_CPU_HI     = 5'h04;
  localparam logic [4:0] OFF_CPU_LO     = 5'h08;
  localparam logic [4:0] OFF_SUP_HI     = 5'h0C;
  localparam logic [4:0] OFF_SUP_LO     = 5'h10;
  localparam logic [4:0] OFF_STATUS     = 5'h14;
  localparam logic [4:0] OFF_RESULT     = 5'h18;

  // ----------------------------------------------------------------
  // Translation control field layout
  // ----------------------------------------------------------------
  localparam int TC_ENABLE      = 31;
  localparam int TC_SUP_ROOT    = 25;
  localparam int TC_FC_LOOKUP   = 24;
  localparam int TC_PAGE_LSB    = 20;
  localparam int TC_SHIFT_LSB   = 16;
  localparam int TC_LVL_A_LSB   = 12;
  localparam int TC_FIELD_W     = 4;

  // Root pointer and long descriptor upper word
  localparam int RP_LOWER_LIM   = 31;
  localparam int RP_LIMIT_LSB   = 16;
  localparam int RP_LIMIT_W     = 15;

  // Status register bits
  localparam int ST_BUS_ERR     = 0;
  localparam int ST_CFG_ERR     = 1;
  localparam int ST_CFG_BAD     = 2;
  localparam int ST_BUSY        = 3;

  // ----------------------------------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] ROOT_RESET    = 32'h0000_0000;
  localparam logic [31:0] ALIGN_MASK    = 32'hFFFF_FFF0;
  localparam logic [5:0]  ADDR_BITS     = 6'h20;
  localparam logic [3:0]  PAGE_MIN      = 4'h8;
  localparam logic [3:0]  FC_INDEX_W    = 4'h3;
  localparam logic [2:0]  FC_CPU_SPACE  = 3'h7;

  // Descriptor type encodings
  typedef enum logic [1:0] {
    DT_INVALID = 2'b00,
    DT_PAGE    = 2'b01,
    DT_SHORT   = 2'b10,
    DT_LONG    = 2'b11
  } desc_type_t;

  // Tree levels
  typedef enum logic [2:0] {
    LVL_FC = 3'b000,
    LVL_A  = 3'b001,
    LVL_B  = 3'b010,
    LVL_C  = 3'b011,
    LVL_D  = 3'b100
  } level_t;

  // Walker states
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_ROOT   = 3'b001,
    S_INDEX  = 3'b010,
    S_FETCH0 = 3'b011,
    S_FETCH1 = 3'b100,
    S_DECODE = 3'b101
  } walk_state_t;

  // Mask of the n lowest bits
  function automatic logic [31:0] lowMask(input logic [5:0] n);
    lowMask = (n >= ADDR_BITS) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
  endfunction

endpackage

// ==== verification/desc_mem.sv ====
`timescale 1ns/10ps
module desc_mem (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Fetch port
  input  wire logic        fetchReq,
  input  wire logic [31:0] fetchAddr,
  input  wire logic [3:0]  lat,
  output logic             fetchAck,
  output logic [31:0]      fetchData
);
  // Word store; tables keep one entry format each
  logic [31:0] mem [0:127];
  logic [3:0]  cnt;
  // Ack after lat idle cycles; data toggles when not valid, so stale reads show
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt       <= 4'h0;
      fetchAck  <= 1'b0;
      fetchData <= 32'h0;
    end else if (fetchReq && !fetchAck && cnt >= lat) begin
      fetchAck  <= 1'b1;
      fetchData <= mem[fetchAddr[8:2]];
      cnt       <= 4'h0;
    end else begin
      fetchAck  <= 1'b0;
      fetchData <= ~fetchData;
      cnt       <= (fetchReq && !fetchAck) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== verification/translation_tree_walk_control_tb.sv ====
`timescale 1ns/10ps
module translation_tree_walk_control_tb;
  logic mclk = 0, rstn = 0, regWr = 0, regRd = 0, transReq = 0, fetchReq, fetchAck;
  logic transDone, transBusErr, transCfgErr;
  logic [4:0]  regAddr = 5'h00;
  logic [2:0]  transFc = 3'h0;
  logic [3:0]  lat = 4'h0;
  logic [31:0] regWdata = 32'h0, transAddr = 32'h0, regRdata, transPhys, fetchAddr, fetchData;
  int error_cnt = 0, total_checks = 0, cyc = 0, tn = 0;
  translation_tree_walk_control dut_u (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .transReq(transReq), .transFc(transFc), .transAddr(transAddr), .transDone(transDone),
    .transPhys(transPhys), .transBusErr(transBusErr), .transCfgErr(transCfgErr),
    .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchAck(fetchAck), .fetchData(fetchData));
  desc_mem mem_u (.mclk(mclk), .rstn(rstn), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .lat(lat), .fetchAck(fetchAck), .fetchData(fetchData));
  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk) begin regAddr <= a; regWdata <= d; regWr <= 1'b1; end
    @(posedge mclk) regWr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge mclk) begin regAddr <= a; regRd <= 1'b1; end
    @(posedge mclk) regRd <= 1'b0;
    #1 chk(e, regRdata);
  endtask
  // One request; waits for done under a bound, then checks the outcome
  task automatic req(input logic [2:0] f, input logic [31:0] a, input logic [31:0] ep,
                     input logic eb, input logic ec);
    int i;
    @(posedge mclk) begin transFc <= f; transAddr <= a; transReq <= 1'b1; end
    @(posedge mclk) transReq <= 1'b0;
    for (i = 0; i < 80; i++) begin
      #1 if (transDone === 1'b1) break;
      @(posedge mclk);
    end
    chk(32'h1, {31'h0, transDone});
    chk({31'h0, eb}, {31'h0, transBusErr});
    chk({31'h0, ec}, {31'h0, transCfgErr});
    if (!eb && !ec) chk(ep, transPhys);
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mem_u.mem[7'h43] = 32'h0055_5001;
    mem_u.mem[7'h44] = 32'h0000_0000;
    mem_u.mem[7'h42] = 32'h7FFF_0002;
    mem_u.mem[7'h03] = 32'h0077_7001;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rd(5'h00, 32'h0);
    rd(5'h1C, 32'h0);
    req(3'h1, 32'h1234_5678, 32'h1234_5678, 0, 0);
    wr(5'h00, 32'h80C4_F000);
    req(3'h1, 32'h0000_3ABC, 32'h0, 0, 1);
    rd(5'h14, 32'h6);
    wr(5'h00, 32'h80C5_F000);
    wr(5'h14, 32'h2);
    rd(5'h14, 32'h0);
    req(3'h7, 32'hABCD_0123, 32'hABCD_0123, 0, 0);
    wr(5'h04, 32'h7FFF_0002);
    wr(5'h08, 32'h0000_0100);
    req(3'h1, 32'h0000_3ABC, 32'h0055_5ABC, 0, 0);
    lat <= 4'h3;
    req(3'h1, 32'h0000_4ABC, 32'h0, 1, 0);
    wr(5'h04, 32'h0002_0002);
    req(3'h1, 32'h0000_3ABC, 32'h0, 1, 0);
    rd(5'h14, 32'h1);
    wr(5'h04, 32'h0000_0001);
    wr(5'h08, 32'h4000_0000);
    req(3'h1, 32'h0123_4567, 32'h4123_4567, 0, 0);
    rd(5'h18, 32'h4123_4567);
    // FC level from a long root, long pointer, then short page table
    wr(5'h00, 32'h81C5_F000);
    wr(5'h04, 32'h7FFF_0003);
    wr(5'h08, 32'h0000_0100);
    req(3'h1, 32'h0000_3ABC, 32'h0077_7ABC, 0, 0);
    wr(5'h00, 32'h83C5_F000);
    req(3'h5, 32'h0000_3ABC, 32'h0, 1, 0);
    results();
  end
endmodule

// ==== verification/tree_walk_chk.sv ====
`timescale 1ns/10ps
module tree_walk_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic        transReq,
  input wire logic [2:0]  transFc,
  input wire logic [31:0] transAddr,
  input wire logic        transDone,
  input wire logic [31:0] transPhys,
  input wire logic        transBusErr,
  input wire logic        transCfgErr,
  input wire logic        fetchReq,
  input wire logic [31:0] fetchAddr,
  input wire logic        fetchAck
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Processor-space request
  sequence s_bypass;
    transReq && transFc == 3'h7;
  endsequence
  a_read_stands: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its cycle");
  a_done_pulse: assert property (transDone |=> !transDone)
    else $error("done longer than one cycle");
  a_err_with_done: assert property (transBusErr |-> transDone && !transCfgErr)
    else $error("bus error without done");
  a_cfg_with_done: assert property (transCfgErr |-> transDone && !fetchReq)
    else $error("config error without done");
  a_fetch_hold: assert property (fetchReq && !fetchAck |=> fetchReq && $stable(fetchAddr))
    else $error("fetch dropped before ack");
  a_long_step: assert property (fetchReq && fetchAck ##1 fetchReq |->
    fetchAddr == $past(fetchAddr) + 32'h4) else $error("second word not at +4");
  a_word_align: assert property (fetchReq |-> fetchAddr[1:0] == 2'b00)
    else $error("fetch not word aligned");
  a_bypass_phys: assert property (s_bypass ##1 transDone && !transCfgErr |->
    transPhys == $past(transAddr)) else $error("bypass address changed");
endmodule
bind translation_tree_walk_control tree_walk_chk chk_u (.mclk(mclk), .rstn(rstn), .regRd(regRd),
  .regRdata(regRdata), .transReq(transReq), .transFc(transFc), .transAddr(transAddr),
  .transDone(transDone), .transPhys(transPhys), .transBusErr(transBusErr),
  .transCfgErr(transCfgErr), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchAck(fetchAck));
